// ### pkg/sfsp_defs.svh
`ifndef SFSP_DEFS_SVH
`define SFSP_DEFS_SVH
`define SFSP_SFR_BASE 8'h80
`define SFSP_SP_ADDR 8'h81
`define SFSP_SP_RESET 8'h07
`define SFSP_BIT_NIB_A 4'h0
`define SFSP_BIT_NIB_B 4'h8
`define SFSP_BIT_RAM_NIB 4'h2
`define SFSP_BANK_TOP 8'h1f
`define SFSP_RAM_DEPTH 256
`endif

// ### pkg/sfsp_pkg.sv
package sfsp_pkg;
  typedef enum logic [1:0] {
    SFSP_MODE_DIRECT = 2'b00,
    SFSP_MODE_INDIRECT = 2'b01,
    SFSP_MODE_BIT = 2'b10
  } sfsp_mode_t;
  typedef enum logic [1:0] {
    SFSP_STK_NONE = 2'b00,
    SFSP_STK_PUSH = 2'b01,
    SFSP_STK_POP = 2'b10
  } sfsp_stk_t;
  typedef struct packed {
    logic valid;
    logic write;
    sfsp_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfsp_req_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] bitMask;
  } sfsp_sfr_t;
endpackage

// ### src/sfsp_ram.sv
`timescale 1ns/10ps
`include "sfsp_defs.svh"
module sfsp_ram (
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  // Full 256 bytes: lower half plus the upper half reached only by indirect and stack accesses
  logic [7:0] mem [0:`SFSP_RAM_DEPTH-1];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### src/sfsp_top.sv
`timescale 1ns/10ps
`include "sfsp_defs.svh"
// Behaviour
// RQ1: Direct access 0x80-0xFF goes to SFRs
// RQ2: Low nibble 0x0/0x8 SFRs allow bit access
// RQ3: Other SFRs byte access only
// RQ4: Software avoids unoccupied SPECIAL_FUNCTION_REGISTER addresses
// RQ5: Stack pointer register lives at 0x81
// RQ6: Stack pointer holds last filled location
// RQ7: Push writes SP+1, then increments SP
// RQ8: Any reset loads stack pointer 0x07
// RQ9: Stack anywhere in 256-byte RAM
// RQ10: Software moves SP when banks used
// RQ11: Peripheral SFRs added, instruction set unchanged
// RQ12: Indirect above 0x7F reaches upper RAM
// RQ13: Locations 0x00-0x1F form four register banks
// RQ14: Pop reads at SP, then decrements SP
module sfsp_top (
  input wire logic clk,
  input wire logic rst_n,
  input sfsp_pkg::sfsp_req_t req,
  input sfsp_pkg::sfsp_stk_t stackOp,
  input wire logic [7:0] pushData,
  input wire logic [1:0] bankSel,
  input wire logic [2:0] bankReg,
  input wire logic bankRead,
  output logic [7:0] rdata,
  output logic rdataValid,
  output logic bitRefused,
  output logic [7:0] stackPointer,
  output sfsp_pkg::sfsp_sfr_t sfrReq,
  input wire logic [7:0] sfrRdata
);
  import sfsp_pkg::*;

  logic [7:0] stackPointer_r;
  logic [7:0] stackPointer_nxt;
  logic [7:0] rdata_r;
  logic rdataValid_r;
  logic fromSfr_r;
  logic fromSp_r;
  logic fromRam_r;
  logic bitRefused_r;
  logic [7:0] bitSel_r;
  logic bitMode_r;
  logic sfrValid_r;
  logic sfrWrite_r;
  logic [7:0] sfrAddr_r;
  logic [7:0] sfrWdata_r;
  logic [7:0] sfrMask_r;
  logic [7:0] ramRdata;

  wire isDirect = req.mode == SFSP_MODE_DIRECT;
  wire isBit = req.mode == SFSP_MODE_BIT;
  wire isIndirect = req.mode == SFSP_MODE_INDIRECT;
  // Bit address: upper half names an SPECIAL_FUNCTION_REGISTER byte, lower half bytes 0x20-0x2F
  wire [7:0] bitByte = req.addr[7] ? {req.addr[7:3], 3'h0} : {`SFSP_BIT_RAM_NIB, req.addr[6:3]};
  wire [7:0] bitMask = 8'h01 << req.addr[2:0];
  // RQ1: direct upper half selects SFRs
  wire hitSfrByte = req.valid && isDirect && req.addr >= `SFSP_SFR_BASE;
  // RQ2: only nibble 0x0 or 0x8 SFRs are bit targets
  wire bitNibOk = bitByte[3:0] == `SFSP_BIT_NIB_A || bitByte[3:0] == `SFSP_BIT_NIB_B;
  wire hitSfrBit = req.valid && isBit && req.addr[7] && bitNibOk;
  // RQ3: bit access elsewhere in SPECIAL_FUNCTION_REGISTER space is refused
  wire refuseBit = req.valid && isBit && req.addr[7] && !bitNibOk;
  wire hitSfr = hitSfrByte || hitSfrBit;
  wire [7:0] sfrAddr = hitSfrBit ? bitByte : req.addr;
  // RQ5: stack pointer decoded at its own address
  wire hitSp = hitSfr && sfrAddr == `SFSP_SP_ADDR;
  // RQ12: indirect above 0x7F and direct below go to RAM
  wire hitRam = req.valid && (isIndirect || (isDirect && !req.addr[7])
    || (isBit && !req.addr[7]));
  wire [7:0] ramByteAddr = isBit ? bitByte : req.addr;
  // RQ13: bank register address is bank times eight plus index
  wire [7:0] bankAddr = {3'h0, bankSel, bankReg};
  wire isPush = stackOp == SFSP_STK_PUSH;
  wire isPop = stackOp == SFSP_STK_POP;
  // RQ7: push target is one above the pointer
  wire [7:0] pushAddr = stackPointer_r + 8'h01;
  // RQ9: 8-bit pointer spans all 256 bytes
  wire [7:0] ramRaddr = isPop ? stackPointer_r : (bankRead ? bankAddr : ramByteAddr);
  wire ramByteWe = hitRam && req.write && !isBit;
  // Bit writes to RAM are dropped: only pushes and non-bit byte writes drive the RAM write enable
  wire ramWe = isPush || ramByteWe;
  wire [7:0] ramWaddr = isPush ? pushAddr : req.addr;
  wire [7:0] ramWdata = isPush ? pushData : req.wdata;
  wire [7:0] spBitVal = (stackPointer_r & ~bitMask) | (req.wdata[0] ? bitMask : 8'h00);
  wire [7:0] sfrWdata = hitSfrBit ? (req.wdata[0] ? bitMask : 8'h00) : req.wdata;
  wire [7:0] sfrMask = hitSfrBit ? bitMask : 8'hff;

  // RQ6: pointer tracks pushes, pops and register writes
  always_comb begin
    stackPointer_nxt = stackPointer_r;
    if (isPush) begin
      stackPointer_nxt = pushAddr;
    end else if (isPop) begin
      // RQ14: pop decrements with 8-bit wrap
      stackPointer_nxt = stackPointer_r - 8'h01;
    end else if (hitSp && req.write) begin
      stackPointer_nxt = hitSfrBit ? spBitVal : req.wdata;
    end
  end

  // RQ8: reset value 0x07
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stackPointer_r <= `SFSP_SP_RESET;
    end else begin
      stackPointer_r <= stackPointer_nxt;
    end
  end

  // RQ11: other SFRs pass to the peripheral side untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrValid_r <= 1'b0;
    end else begin
      sfrValid_r <= hitSfr && !hitSp;
    end
  end

  // Payload reset too, so an idle bus never shows stale values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrWrite_r <= 1'b0;
    end else begin
      sfrWrite_r <= req.write;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrAddr_r <= 8'h00;
    end else begin
      sfrAddr_r <= sfrAddr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrWdata_r <= 8'h00;
    end else begin
      sfrWdata_r <= sfrWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrMask_r <= 8'h00;
    end else begin
      sfrMask_r <= sfrMask;
    end
  end

  // Read answer stands one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdataValid_r <= 1'b0;
    end else begin
      rdataValid_r <= (req.valid && !req.write && !refuseBit) || isPop || bankRead;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fromSp_r <= 1'b0;
    end else begin
      fromSp_r <= hitSp;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fromSfr_r <= 1'b0;
    end else begin
      fromSfr_r <= hitSfr && !hitSp;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fromRam_r <= 1'b0;
    end else begin
      fromRam_r <= hitRam || isPop || bankRead;
    end
  end

  // RQ3: refusal flagged for one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitRefused_r <= 1'b0;
    end else begin
      bitRefused_r <= refuseBit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitSel_r <= 8'h00;
    end else begin
      bitSel_r <= bitMask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitMode_r <= 1'b0;
    end else begin
      bitMode_r <= isBit && !isPop && !bankRead;
    end
  end

  sfsp_ram u_ram (
    .clk(clk),
    .we(ramWe),
    .waddr(ramWaddr),
    .wdata(ramWdata),
    .raddr(ramRaddr),
    .rdata(ramRdata)
  );

  wire [7:0] byteOut = fromSp_r ? stackPointer_r : (fromSfr_r ? sfrRdata :
    (fromRam_r ? ramRdata : 8'h00));
  // Bit reads return the selected bit in bit 0
  wire [7:0] readOut = bitMode_r ? {7'h00, |(byteOut & bitSel_r)} : byteOut;

  always_comb begin
    rdata_r = rdataValid_r ? readOut : 8'h00;
  end

  assign rdata = rdata_r;
  assign rdataValid = rdataValid_r;
  assign bitRefused = bitRefused_r;
  assign stackPointer = stackPointer_r;
  assign sfrReq = '{valid: sfrValid_r, write: sfrWrite_r, addr: sfrAddr_r,
    wdata: sfrWdata_r, bitMask: sfrMask_r};
endmodule

// ### tb/sfsp_top_asserts.sv
`timescale 1ns/10ps
module sfsp_top_checker (
  input wire logic clk,
  input wire logic rst_n,
  input sfsp_pkg::sfsp_req_t req,
  input sfsp_pkg::sfsp_stk_t stackOp,
  input wire logic bankRead,
  input wire logic rdataValid,
  input wire logic bitRefused,
  input wire logic [7:0] stackPointer,
  input sfsp_pkg::sfsp_sfr_t sfrReq
);
  import sfsp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire dirReq = req.valid && req.mode == SFSP_MODE_DIRECT && stackOp == SFSP_STK_NONE;
  AST_SP_RST: assert property ($rose(rst_n) |-> stackPointer == 8'h07)
    else $error("stack pointer reset value");
  AST_PUSH: assert property (stackOp == SFSP_STK_PUSH |=>
    stackPointer == $past(stackPointer) + 8'h01) else $error("push step");
  AST_POP: assert property (stackOp == SFSP_STK_POP |=>
    rdataValid && stackPointer == $past(stackPointer) - 8'h01) else $error("pop step");
  AST_SP_WR: assert property (dirReq && req.write && req.addr == 8'h81 |=>
    stackPointer == $past(req.wdata) && !sfrReq.valid) else $error("sp write");
  AST_SFR: assert property (dirReq && req.addr[7] && req.addr != 8'h81 |=>
    sfrReq.valid && sfrReq.addr == $past(req.addr) && sfrReq.bitMask == 8'hff)
    else $error("direct sfr route");
  AST_IND: assert property (req.valid && req.mode == SFSP_MODE_INDIRECT |=>
    !sfrReq.valid) else $error("indirect went to sfr");
  AST_BIT: assert property (req.valid && req.mode == SFSP_MODE_BIT && req.addr[7] |=>
    sfrReq.valid && sfrReq.addr[2:0] == 3'h0 && $onehot(sfrReq.bitMask) && !bitRefused)
    else $error("sfr bit access");
  AST_BYTE: assert property (sfrReq.valid && sfrReq.addr[2:0] != 3'h0 |->
    sfrReq.bitMask == 8'hff) else $error("bit access on byte sfr");
  AST_BANK: assert property (bankRead && stackOp == SFSP_STK_NONE |=> rdataValid)
    else $error("bank read lost");
endmodule
bind sfsp_top sfsp_top_checker i_chk (.clk(clk), .rst_n(rst_n), .req(req), .stackOp(stackOp),
  .bankRead(bankRead), .rdataValid(rdataValid), .bitRefused(bitRefused),
  .stackPointer(stackPointer), .sfrReq(sfrReq));

// ### tb/sfsp_periph.sv
`timescale 1ns/10ps
module sfsp_periph (
  input wire logic clk,
  input sfsp_pkg::sfsp_sfr_t sfrReq,
  output logic [7:0] sfrRdata
);
  import sfsp_pkg::*;
  logic [7:0] mem [256];
  logic [7:0] lastA = 8'h00;
  logic held = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk) begin
    held <= sfrReq.valid;
    if (sfrReq.valid) lastA <= sfrReq.addr;
    if (sfrReq.valid && sfrReq.write)
      mem[sfrReq.addr] <= (mem[sfrReq.addr] & ~sfrReq.bitMask) | (sfrReq.wdata & sfrReq.bitMask);
  end
  // Released bus holds the last value for one cycle, then shows the inverse
  assign sfrRdata = sfrReq.valid ? mem[sfrReq.addr] : held ? mem[lastA] : ~mem[lastA];
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  import sfsp_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  sfsp_req_t req = '0;
  sfsp_stk_t stackOp = SFSP_STK_NONE;
  logic [7:0] pushData = 0;
  logic [1:0] bankSel = 0;
  logic [2:0] bankReg = 0;
  logic bankRead = 0;
  logic [7:0] rdata, stackPointer, sfrRdata;
  logic rdataValid, bitRefused;
  sfsp_sfr_t sfrReq;
  logic [8:0] expQ [$];
  logic [8:0] note;
  logic [7:0] v [8];
  logic [15:0] seed = 16'hecff;
  int miscompares = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  sfsp_top i_dut (.clk(clk), .rst_n(rst_n), .req(req), .stackOp(stackOp), .pushData(pushData),
    .bankSel(bankSel), .bankReg(bankReg), .bankRead(bankRead), .rdata(rdata),
    .rdataValid(rdataValid), .bitRefused(bitRefused), .stackPointer(stackPointer),
    .sfrReq(sfrReq), .sfrRdata(sfrRdata));
  sfsp_periph i_per (.clk(clk), .sfrReq(sfrReq), .sfrRdata(sfrRdata));
  function automatic logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction
  task automatic drv(sfsp_stk_t s, logic vl, logic w, sfsp_mode_t m, logic [7:0] a,
                     logic [7:0] d, logic b);
    @(posedge clk);
    stackOp <= s;
    pushData <= d;
    req <= '{vl, w, m, a, d};
    bankRead <= b;
    bankSel <= a[4:3];
    bankReg <= a[2:0];
  endtask
  task automatic rd(sfsp_mode_t m, logic [7:0] a, logic [7:0] e);
    expQ.push_back({m == SFSP_MODE_DIRECT && a == 8'h81, e});
    drv(SFSP_STK_NONE, 1, 0, m, a, 0, 0);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(logic [7:0] e);
    check_count++;
    if (rdata !== e) begin
      miscompares++;
      $display("wrong value at %0t: rdata %h expected %h", $time, rdata, e);
    end
  endtask
  task automatic cmpPtr(logic [7:0] e);
    check_count++;
    if (stackPointer !== e) begin
      miscompares++;
      $display("wrong value at %0t: stackPointer %h expected %h", $time, stackPointer, e);
    end
  endtask
  task automatic cmpFlag(logic f);
    check_count++;
    if (f !== 1'b0) begin
      miscompares++;
      $display("wrong value at %0t: bit access refused", $time);
    end
  endtask
  always @(negedge clk) begin
    cyc++;
    cmpFlag(bitRefused);
    if (rdataValid === 1'b1) begin
      note = expQ.size() > 0 ? expQ.pop_front() : 9'h0xx;
      cmp(note[7:0]);
      if (note[8]) cmpPtr(note[7:0]);
    end
    if (cyc == 400) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    rd(SFSP_MODE_DIRECT, 8'h81, 8'h07);
    for (int i = 0; i < 8; i++) begin
      v[i] = rnd();
      drv(SFSP_STK_PUSH, 0, 0, SFSP_MODE_DIRECT, 0, v[i], 0);
    end
    rd(SFSP_MODE_DIRECT, 8'h81, 8'h0f);
    expQ.push_back({1'b0, v[0]});
    drv(SFSP_STK_NONE, 0, 0, SFSP_MODE_DIRECT, 8'h08, 0, 1);
    rd(SFSP_MODE_INDIRECT, 8'h0f, v[7]);
    for (int i = 7; i >= 0; i--) begin
      expQ.push_back({1'b0, v[i]});
      drv(SFSP_STK_POP, 0, 0, SFSP_MODE_DIRECT, 0, 0, 0);
    end
    rd(SFSP_MODE_DIRECT, 8'h81, 8'h07);
    drv(SFSP_STK_NONE, 1, 1, SFSP_MODE_DIRECT, 8'h81, 8'hfe, 0);
    drv(SFSP_STK_PUSH, 0, 0, SFSP_MODE_DIRECT, 0, v[1], 0);
    drv(SFSP_STK_PUSH, 0, 0, SFSP_MODE_DIRECT, 0, v[2], 0);
    rd(SFSP_MODE_DIRECT, 8'h81, 8'h00);
    rd(SFSP_MODE_INDIRECT, 8'hff, v[1]);
    rd(SFSP_MODE_INDIRECT, 8'h00, v[2]);
    drv(SFSP_STK_NONE, 1, 1, SFSP_MODE_DIRECT, 8'ha0, v[3], 0);
    drv(SFSP_STK_NONE, 1, 1, SFSP_MODE_BIT, 8'ha3, 8'hff, 0);
    rd(SFSP_MODE_DIRECT, 8'ha0, v[3] | 8'h08);
    rd(SFSP_MODE_BIT, 8'ha3, 8'h01);
    drv(SFSP_STK_NONE, 1, 1, SFSP_MODE_DIRECT, 8'h22, v[5], 0);
    rd(SFSP_MODE_BIT, 8'h13, {7'h00, v[5][3]});
    drv(SFSP_STK_NONE, 1, 1, SFSP_MODE_DIRECT, 8'ha5, v[4], 0);
    rd(SFSP_MODE_DIRECT, 8'ha5, v[4]);
    drv(SFSP_STK_NONE, 0, 0, SFSP_MODE_DIRECT, 0, 0, 0);
    repeat (2) @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(SFSP_MODE_DIRECT, 8'h81, 8'h07);
    drv(SFSP_STK_NONE, 0, 0, SFSP_MODE_DIRECT, 0, 0, 0);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule
